// ===== rtl/ckgen_top.sv
// clock stop sequencing, self-clock mode and interrupt logic
`timescale 1ns/100ps
`default_nettype none
module ckgen_top
   import ckgen_pkg::*;
#(
   parameter int TICK_W = 16,
   parameter int WDOG_W = 16
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // core requests
   input  wire logic        stop_req,
   input  wire logic        wait_mode,
   input  wire logic        wakeup,
   // analog status
   input  wire logic        pll_lock,
   input  wire logic        clock_lost,
   input  wire logic        quality_ok,
   input  wire logic        quality_fail,
   // clock and power controls
   output logic             pll_clock_select,
   output logic             pll_enable,
   output logic             core_clk_en,
   output logic             sys_clk_en,
   output logic             osc_enable,
   output logic             regulator_enable,
   output logic             power_save_req,
   output logic             stop_active,
   output logic             check_run,
   output logic             check_restart,
   output logic             self_clock_mode,
   output logic             wait_exit,
   // interrupts
   output logic             irq_tick,
   output logic             irq_lock,
   output logic             irq_selfclk,
   output logic             irq
);
   ckgen_state_t state_r;
   logic [6:0]        ctrl_r;
   logic [2:0]        mask_r;
   logic [2:0]        flag_r;
   logic [2:0]        req;
   logic [2:0]        set_ev;
   logic [2:0]        clr_w1;
   logic [15:0]       tick_per_r;
   logic [3:0]        step_r;
   logic              wr_pend_r;
   logic [7:0]        wr_addr_r;
   logic              lock_d_r;
   logic              selfclk_d_r;
   logic              selfclk_nxt;
   logic              full_stop_r;
   logic              tick_run;
   logic              wdog_run;
   logic              tick_wrap;
   logic [TICK_W-1:0] tick_cnt;
   logic [WDOG_W-1:0] wdog_cnt;
   logic              pseudo;
   logic              step_done;

   function automatic logic is_sel(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction

   // ---------------- bus slave ----------------
   // zero wait states; every access is OKAY, unmapped reads give zero
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         wr_addr_r <= haddr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (is_sel(haddr, CKGEN_OFS_CTRL)) begin
            hrdata <= {25'h0, ctrl_r[6:1], pll_clock_select};
         end else if (is_sel(haddr, CKGEN_OFS_STATUS)) begin
            hrdata <= {29'h0, flag_r};
         end else if (is_sel(haddr, CKGEN_OFS_MASK)) begin
            hrdata <= {29'h0, mask_r};
         end else if (is_sel(haddr, CKGEN_OFS_TICK)) begin
            hrdata <= {16'h0, tick_per_r};
         end else if (is_sel(haddr, CKGEN_OFS_STATE)) begin
            hrdata <= {24'h0, pll_lock, self_clock_mode, stop_active,
                       2'b00, state_r};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   wire wr_ctrl = wr_pend_r && is_sel(wr_addr_r, CKGEN_OFS_CTRL);
   wire wr_stat = wr_pend_r && is_sel(wr_addr_r, CKGEN_OFS_STATUS);
   wire wr_mask = wr_pend_r && is_sel(wr_addr_r, CKGEN_OFS_MASK);
   wire wr_tick = wr_pend_r && is_sel(wr_addr_r, CKGEN_OFS_TICK);

   // pll select bit is also cleared by the stop sequence
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_r <= CKGEN_CTRL_RST;
      end else if (state_r == CKGEN_DESEL) begin
         ctrl_r[CKGEN_B_PLLCLK] <= 1'b0; // [R5]
      end else if (wr_ctrl) begin
         ctrl_r <= hwdata[6:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mask_r     <= 3'h0;
         tick_per_r <= CKGEN_TICK_RST;
      end else begin
         if (wr_mask) begin
            mask_r <= hwdata[2:0];
         end
         if (wr_tick) begin
            tick_per_r <= hwdata[15:0];
         end
      end
   end

   assign clr_w1 = wr_stat ? hwdata[2:0] : 3'h0;

   // ---------------- stop sequencer ----------------
   // each gating step waits a few cycles so clocks settle in order
   assign step_done = (step_r == CKGEN_STEP_CYC);
   assign pseudo    = ctrl_r[CKGEN_B_PSEUDO];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         step_r <= 4'h0;
      end else if (state_r == CKGEN_RUN || state_r == CKGEN_STOPPED ||
                   step_done) begin
         step_r <= 4'h0;
      end else begin
         step_r <= step_r + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= CKGEN_RUN;
      end else begin
         unique case (state_r)
            CKGEN_RUN: begin
               if (stop_req) begin
                  state_r <= CKGEN_DESEL; // [R5]
               end
            end
            CKGEN_DESEL: begin
               if (step_done) begin
                  state_r <= CKGEN_PLL_OFF;
               end
            end
            CKGEN_PLL_OFF: begin
               if (step_done) begin
                  state_r <= CKGEN_CORE_OFF;
               end
            end
            CKGEN_CORE_OFF: begin
               if (step_done) begin
                  state_r <= CKGEN_SYS_OFF;
               end
            end
            CKGEN_SYS_OFF: begin
               if (step_done) begin
                  state_r <= CKGEN_STOPPED; // [R5]
               end
            end
            CKGEN_STOPPED: begin
               if (wakeup) begin
                  state_r <= CKGEN_RUN;
               end
            end
            default: begin
               state_r <= CKGEN_RUN;
            end
         endcase
      end
   end

   // remember a full stop so the exit can trigger a fresh check
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         full_stop_r <= 1'b0;
      end else if (state_r == CKGEN_STOPPED && !pseudo) begin
         full_stop_r <= 1'b1;
      end else if (state_r == CKGEN_RUN) begin
         full_stop_r <= 1'b0;
      end
   end

   assign stop_active      = (state_r == CKGEN_STOPPED); // [R5]
   assign pll_clock_select = ctrl_r[CKGEN_B_PLLCLK];
   assign core_clk_en      = (state_r == CKGEN_RUN) ||
                             (state_r == CKGEN_DESEL) ||
                             (state_r == CKGEN_PLL_OFF); // [R5]
   assign sys_clk_en       = core_clk_en || (state_r == CKGEN_CORE_OFF);
   assign osc_enable       = !stop_active || pseudo; // [R1]
   // request goes out in every stop; regulator enable stays separate
   assign power_save_req   = stop_active; // [R4]
   // pll and regulator stay up in pseudo-stop under self-clock mode
   wire pll_keep = pseudo && self_clock_mode; // [R6]
   wire pll_gone = (state_r == CKGEN_CORE_OFF) || (state_r == CKGEN_SYS_OFF)
                   || (state_r == CKGEN_PLL_OFF) || stop_active;
   assign pll_enable  = (ctrl_r[CKGEN_B_PLLON] || self_clock_mode) &&
                        (!pll_gone || pll_keep); // [R5] [R6] [R13]
   assign regulator_enable = !stop_active || pll_keep; // [R4] [R6]
   // full stop aborts an ongoing check, exit restarts a complete one
   assign check_run     = self_clock_mode && !quality_ok &&
                          !(stop_active && !pseudo); // [R6] [R7]
   assign check_restart = full_stop_r && (state_r == CKGEN_STOPPED) &&
                          wakeup; // [R7] [R12]

   // ---------------- self-clock mode ----------------
   always_comb begin
      selfclk_nxt = self_clock_mode;
      if (ctrl_r[CKGEN_B_SCKEN]) begin // [R11]
         if (quality_fail || (ctrl_r[CKGEN_B_MONEN] && clock_lost)) begin
            selfclk_nxt = 1'b1; // [R12]
         end else if (quality_ok) begin
            selfclk_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         self_clock_mode <= 1'b0;
      end else begin
         self_clock_mode <= selfclk_nxt;
      end
   end

   // wait exit on clock loss only with all three enables set
   assign wait_exit = wait_mode && self_clock_mode &&
                      ctrl_r[CKGEN_B_MONEN] && ctrl_r[CKGEN_B_SCKEN] &&
                      mask_r[CKGEN_I_SELFCLK]; // [R13]

   // ---------------- counters ----------------
   assign tick_run = sys_clk_en ||
                     (stop_active && pseudo && ctrl_r[CKGEN_B_PRE]); // [R3]
   assign wdog_run = sys_clk_en ||
                     (stop_active && pseudo && ctrl_r[CKGEN_B_WDRUN]); // [R3]

   ckgen_counter #(.W(TICK_W)) u_tick (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (tick_run),
      .period  (TICK_W'(tick_per_r)),
      .wrap    (tick_wrap),
      .count_r (tick_cnt)
   );

   ckgen_counter #(.W(WDOG_W)) u_wdog (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (wdog_run), // [R2]
      .period  ({WDOG_W{1'b1}}),
      .wrap    (),
      .count_r (wdog_cnt)
   );

   // ---------------- interrupt events ----------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_d_r <= 1'b0;
         selfclk_d_r <= 1'b0;
      end else begin
         lock_d_r <= pll_lock;
         selfclk_d_r <= self_clock_mode;
      end
   end

   assign set_ev[CKGEN_I_TICK]    = tick_wrap; // [R8]
   assign set_ev[CKGEN_I_LOCK]    = pll_lock ^ lock_d_r; // [R9]
   assign set_ev[CKGEN_I_SELFCLK] = self_clock_mode ^ selfclk_d_r; // [R10]

   ckgen_flags #(.N(3)) u_flags (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set_ev  (set_ev),
      .clr_w1  (clr_w1),
      .enable  (mask_r),
      .flag_r  (flag_r),
      .req     (req)
   );

   assign irq_tick    = req[CKGEN_I_TICK]; // [R14]
   assign irq_lock    = req[CKGEN_I_LOCK];
   assign irq_selfclk = req[CKGEN_I_SELFCLK];
   assign irq      = |req;
endmodule
`default_nettype wire

// ===== include/ckgen_pkg.sv
// constants, states and register map of the clock stop and interrupt logic
// Operation
// R1: stop halts clocks and oscillator; pseudo-stop keeps the oscillator running.
// R2: counters and dividers freeze in stop and resume without reinitialising.
// R3: tick and watchdog counters keep counting in pseudo-stop when enabled.
// R4: stop entry also raises power-saving requests to the voltage regulator.
// R5: stop sequence: deselect pll clock, pll off, core off, system off.
// R6: pseudo-stop in self-clock mode keeps pll, regulator, quality checks running.
// R7: full stop in self-clock mode aborts check; full check restarts on exit.
// R8: tick period elapse sets realtime flag; write one clears; enable gates.
// R9: lock change either way sets lock flag; write one clears; enable gates.
// R10: self-clock entry or exit sets flag; write one clears; enable gates.
// R11: self-clock mode may change only while its enable bit is set.
// R12: self-clock entry on failed check after reset, stop recovery, or clock loss.
// R13: clock loss in wait with all enables starts pll, regulator, self-clock mode.
// R14: each interrupt request is its flag AND its local enable.
package ckgen_pkg;
   localparam logic [7:0] CKGEN_OFS_CTRL   = 8'h00;
   localparam logic [7:0] CKGEN_OFS_STATUS = 8'h04;
   localparam logic [7:0] CKGEN_OFS_MASK   = 8'h08;
   localparam logic [7:0] CKGEN_OFS_TICK   = 8'h0c;
   localparam logic [7:0] CKGEN_OFS_STATE  = 8'h10;
   // control register bit positions
   localparam int CKGEN_B_PLLCLK = 0;
   localparam int CKGEN_B_PSEUDO = 1;
   localparam int CKGEN_B_PRE    = 2;
   localparam int CKGEN_B_WDRUN  = 3;
   localparam int CKGEN_B_SCKEN  = 4;
   localparam int CKGEN_B_MONEN  = 5;
   localparam int CKGEN_B_PLLON  = 6;
   // status and mask bit positions
   localparam int CKGEN_I_TICK    = 0;
   localparam int CKGEN_I_LOCK    = 1;
   localparam int CKGEN_I_SELFCLK = 2;
   localparam logic [6:0]  CKGEN_CTRL_RST = 7'h50;
   localparam logic [15:0] CKGEN_TICK_RST = 16'h00ff;
   localparam logic [3:0]  CKGEN_STEP_CYC = 4'h2;
   typedef enum logic [2:0] {
      CKGEN_RUN      = 3'b000,
      CKGEN_DESEL    = 3'b001,
      CKGEN_PLL_OFF  = 3'b010,
      CKGEN_CORE_OFF = 3'b011,
      CKGEN_SYS_OFF  = 3'b100,
      CKGEN_STOPPED  = 3'b101
   } ckgen_state_t;
endpackage

// ===== rtl/ckgen_counter.sv
// free counter with freeze input, wraps with a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module ckgen_counter
   import ckgen_pkg::*;
#(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // control
   input  wire logic         run,
   input  wire logic [W-1:0] period,
   // status
   output logic              wrap,
   output logic [W-1:0]      count_r
);
   // frozen value is kept, never reloaded [R2]
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_r <= '0;
      end else if (run) begin
         count_r <= (count_r >= period) ? '0 : count_r + 1'b1;
      end
   end
   assign wrap = run && (count_r >= period);
endmodule
`default_nettype wire

// ===== rtl/ckgen_flags.sv
// sticky interrupt flags, write-one-to-clear, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module ckgen_flags
   import ckgen_pkg::*;
#(
   parameter int N = 3
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // events and clears
   input  wire logic [N-1:0] set_ev,
   input  wire logic [N-1:0] clr_w1,
   input  wire logic [N-1:0] enable,
   // outputs
   output logic [N-1:0]      flag_r,
   output logic [N-1:0]      req
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               flag_r[i] <= 1'b0;
            end else if (set_ev[i]) begin
               flag_r[i] <= 1'b1; // [R8] [R9] [R10]
            end else if (clr_w1[i]) begin
               flag_r[i] <= 1'b0;
            end
         end
         assign req[i] = flag_r[i] & enable[i]; // [R14]
      end
   endgenerate
endmodule
`default_nettype wire

// ===== tb/ckgen_properties.sv
// assertion checker for the clock stop and interrupt block
`timescale 1ns/100ps
`default_nettype none
module ckgen_properties (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // bus and core
   input  wire logic [1:0] htrans,
   input  wire logic       hwrite,
   input  wire logic       wakeup,
   input  wire logic       pll_lock,
   // clock and power controls
   input  wire logic       pll_clock_select,
   input  wire logic       pll_enable,
   input  wire logic       core_clk_en,
   input  wire logic       sys_clk_en,
   input  wire logic       osc_enable,
   input  wire logic       regulator_enable,
   input  wire logic       power_save_req,
   input  wire logic       stop_active,
   input  wire logic       check_restart,
   input  wire logic       self_clock_mode,
   // interrupts
   input  wire logic       irq_tick,
   input  wire logic       irq_lock,
   input  wire logic       irq_selfclk,
   input  wire logic       irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_irq_or;
      irq == (irq_tick | irq_lock | irq_selfclk);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq not or");
   property p_sel_first;
      $fell(pll_enable) |-> !pll_clock_select;
   endproperty
   a_sel_first: assert property (p_sel_first) else $error("pll sel");
   property p_core_first;
      $fell(sys_clk_en) |-> !core_clk_en && (!pll_enable || self_clock_mode);
   endproperty
   a_core_first: assert property (p_core_first) else $error("order");
   property p_all_off;
      stop_active |-> !core_clk_en && !sys_clk_en && power_save_req;
   endproperty
   a_all_off: assert property (p_all_off) else $error("clk on");
   property p_osc;
      !osc_enable |-> !sys_clk_en;
   endproperty
   a_osc: assert property (p_osc) else $error("osc off early");
   property p_pseudo_selfclk;
      stop_active && osc_enable && self_clock_mode |->
         pll_enable && regulator_enable;
   endproperty
   a_pseudo_selfclk: assert property (p_pseudo_selfclk)
      else $error("pll off");
   property p_restart;
      check_restart |-> stop_active && wakeup;
   endproperty
   a_restart: assert property (p_restart) else $error("restart");
   // lock flag may also reach irq through a mask write two cycles back
   property p_lock;
      $rose(irq_lock) |-> $past(pll_lock) != $past(pll_lock, 2) ||
         $past(pll_lock, 2) != $past(pll_lock, 3) ||
         ($past(htrans[1], 2) && $past(hwrite, 2));
   endproperty
   a_lock: assert property (p_lock) else $error("lock irq");
   property p_selfclk_pwr;
      $rose(self_clock_mode) |-> pll_enable && regulator_enable;
   endproperty
   a_selfclk_pwr: assert property (p_selfclk_pwr)
      else $error("self clock power");
endmodule
bind ckgen_top ckgen_properties u_props (.clk_sys, .rst, .htrans, .hwrite,
   .wakeup, .pll_lock, .pll_clock_select, .pll_enable, .core_clk_en,
   .sys_clk_en, .osc_enable, .regulator_enable, .power_save_req,
   .stop_active, .check_restart, .self_clock_mode, .irq_tick, .irq_lock,
   .irq_selfclk, .irq);
`default_nettype wire

// ===== tb/ckgen_core_model.sv
// core model: asks for stop and wakes the block
`timescale 1ns/100ps
`default_nettype none
module ckgen_core_model (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // bench commands
   input  wire logic go,
   input  wire logic wake,
   // block status
   input  wire logic stop_active,
   input  wire logic irq,
   // requests
   output logic      stop_req,
   output logic      wakeup
);
   // request held until stop is reached, as a stalled core would
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stop_req <= 1'b0;
         wakeup   <= 1'b0;
      end else begin
         stop_req <= (stop_req | go) & ~stop_active;
         wakeup   <= stop_active & (wake | irq);
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the clock stop and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk_sys, rst, hsel, hwrite, stop_req, wait_mode, wakeup;
   logic        pll_lock, clock_lost, quality_ok, go, wake, hreadyout;
   logic        hresp, pll_clock_select, pll_enable, core_clk_en, sys_clk_en;
   logic        osc_enable, regulator_enable, power_save_req, stop_active;
   logic        check_run, check_restart, self_clock_mode, wait_exit;
   logic        irq_tick, irq_lock, irq_selfclk, irq;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rdv;
   int          bad_count, tests_run, per;
   logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   int          rv[$] = '{32'h50, 0, 0, 32'hff, 0, 0};
   always #20 clk_sys = ~clk_sys;
   ckgen_top DUT (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .stop_req, .wait_mode, .wakeup, .pll_lock, .clock_lost,
      .quality_ok, .quality_fail(1'b0), .pll_clock_select, .pll_enable,
      .core_clk_en, .sys_clk_en, .osc_enable, .regulator_enable,
      .power_save_req, .stop_active, .check_run, .check_restart,
      .self_clock_mode, .wait_exit, .irq_tick, .irq_lock, .irq_selfclk,
      .irq);
   ckgen_core_model u_core (.clk_sys, .rst, .go, .wake, .stop_active, .irq,
      .stop_req, .wakeup);
   task end_sim;
      $display("mismatches %0d checks %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rdy;
      int i;
      for (i = 0; i == 0 || (hreadyout !== 1'b1 && i < 400); i++)
         @(posedge clk_sys);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         end_sim();
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
      rdv = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdv & m, e);
   endtask
   function logic sig(input int s);
      case (s)
         0: return irq;
         1: return stop_active;
         2: return self_clock_mode;
         3: return wait_exit;
         default: return check_restart;
      endcase
   endfunction
   task wcnd(input int s, input logic v);
      int i;
      // poll at the falling edge, away from the launching edge
      for (i = 0; i == 0 || (i < 400 && sig(s) !== v); i++)
         @(negedge clk_sys);
      chk(sig(s), v);
      @(posedge clk_sys);
      if (i == 400) end_sim();
   endtask
   task stopit;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      wcnd(1, 1);
   endtask
   task resume;
      wake <= 1'b1;
      wcnd(1, 0);
      wake <= 1'b0;
   endtask
   initial begin
      {clk_sys, hsel, hwrite, wait_mode, pll_lock, go, wake} = '0;
      {clock_lost, quality_ok, haddr, htrans, hwdata} = '0;
      rst = 1'b1;
      bad_count = 0;
      tests_run = 0;
      void'($urandom(63408));
      per = $urandom_range(40, 20);
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int k = 0; k < 6; k++) rd(ra[k], 32'hffffffff, 32'(rv[k]));
      wr(8'h0c, 32'(per));
      wr(8'h08, 32'h1);
      wcnd(0, 1);
      chk(irq_tick, 1);
      rd(8'h04, 32'h1, 32'h1);
      wr(8'h04, 32'h1);
      @(posedge clk_sys);
      chk(irq, 0);
      wr(8'h08, 32'h0);
      repeat (per + 4) @(posedge clk_sys);
      chk(irq, 0);
      rd(8'h04, 32'h1, 32'h1);
      wr(8'h08, 32'h2);
      repeat ($urandom_range(3, 1)) begin
         pll_lock <= ~pll_lock;
         wcnd(0, 1);
         chk(irq_lock, 1);
         wr(8'h04, 32'h2);
         rd(8'h04, 32'h2, 32'h0);
      end
      wr(8'h04, 32'h7);
      wr(8'h08, 32'h4);
      wr(8'h00, 32'h60);
      rd(8'h00, 32'h7f, 32'h60);
      clock_lost <= 1'b1;
      wait_mode <= 1'b1;
      repeat (20) @(posedge clk_sys);
      chk(self_clock_mode, 0);
      wr(8'h00, 32'h70);
      wcnd(2, 1);
      wcnd(0, 1);
      chk(pll_enable & regulator_enable, 1);
      wcnd(3, 1);
      wait_mode <= 1'b0;
      wr(8'h04, 32'h4);
      wr(8'h00, 32'h72);
      stopit();
      chk({pll_enable, regulator_enable, check_run}, 3'b111);
      resume();
      wr(8'h00, 32'h70);
      stopit();
      chk({check_run, osc_enable}, 2'b00);
      wake <= 1'b1;
      wcnd(4, 1);
      wcnd(1, 0);
      wake <= 1'b0;
      clock_lost <= 1'b0;
      quality_ok <= 1'b1;
      wcnd(2, 0);
      rd(8'h04, 32'h4, 32'h4);
      quality_ok <= 1'b0;
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h51);
      stopit();
      chk(pll_clock_select, 0);
      chk({osc_enable, core_clk_en, power_save_req}, 3'b001);
      resume();
      // without its run bit the tick counter stays frozen while stopped
      for (int pre = 1; pre >= 0; pre--) begin
         wr(8'h00, 32'h52 | 32'(pre * 4));
         stopit();
         wr(8'h04, 32'h1);
         repeat (2 * per) @(posedge clk_sys);
         chk(osc_enable, 1);
         rd(8'h04, 32'h1, 32'(pre));
         resume();
      end
      end_sim();
   end
endmodule
`default_nettype wire
